// File: power_seq_pkg.sv
// constants and types shared by the slot power sequencer files
// Contract
// - pin port: main, aux enables, fault outputs
// - serial management port with interrupt output
// - serial-only or pin power control setups
// - host reads voltage, current, faults per supply
// - reset ends after standby valid 500us
// - reset clears all but conversion result
// - standby dropout restarts full qualification
// - fault cleared by cycling matching enable
// - fault pin only when pin-enabled
package power_seq_pkg;
    // clock rate and power-on qualification time
    localparam int MCLK_MHZ        = 250;
    localparam int POR_QUAL_US     = 500;
    localparam int POR_QUAL_CYCLES = POR_QUAL_US * MCLK_MHZ;
    // serial command codes
    localparam logic [7:0] CMD_CTL_A       = 8'h00;
    localparam logic [7:0] CMD_CTL_B       = 8'h01;
    localparam logic [7:0] CMD_STAT_A      = 8'h02;
    localparam logic [7:0] CMD_STAT_B      = 8'h03;
    localparam logic [7:0] CMD_CFG         = 8'h04;
    localparam logic [7:0] CMD_RESULT_BASE = 8'h10;
    // field positions
    localparam int CTL_MAIN_BIT   = 0;
    localparam int CTL_AUX_BIT    = 1;
    localparam int STAT_MAIN_BIT  = 0;
    localparam int STAT_AUX_BIT   = 1;
    localparam int STAT_PIN_BIT   = 2;
    localparam int CFG_SERIAL_BIT = 0;
    // reset values
    localparam logic [1:0] CTL_RESET = 2'h0;
    localparam logic       CFG_RESET = 1'b0;
    // result store geometry
    localparam int RESULT_AW = 4;
    localparam int RESULT_DW = 8;
    // serial slave address, value arbitrary
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2c;
    // serial slave byte phases
    typedef enum logic [2:0]
    {
        SMB_IDLE  = 3'b000,
        SMB_ADDR  = 3'b001,
        SMB_CMD   = 3'b010,
        SMB_WDATA = 3'b011,
        SMB_RDATA = 3'b100
    } smb_state_t;
endpackage

// File: result_mem.sv
// conversion result store, deliberately outside every reset
module result_mem
    import power_seq_pkg::*;
(
    // clock
    input  wire logic   mclk_i,
    // access port
    result_mem_if.store mem
);
    // one byte per supply channel
    logic [RESULT_DW-1:0] words [2**RESULT_AW];

    // write port, kept across power-on reset
    always_ff @(posedge mclk_i)
    begin
        if (mem.wr_en)
        begin
            words[mem.wr_addr] <= mem.wr_data;
        end
    end

    // registered read port
    always_ff @(posedge mclk_i)
    begin
        mem.rd_data <= words[mem.rd_addr];
    end
endmodule

// File: result_mem_if.sv
// carrier between the sequencer and its conversion result store
interface result_mem_if
    import power_seq_pkg::*;
();
    logic                 wr_en;   // store one result
    logic [RESULT_AW-1:0] wr_addr; // supply channel written
    logic [RESULT_DW-1:0] wr_data; // result byte
    logic [RESULT_AW-1:0] rd_addr; // channel read
    logic [RESULT_DW-1:0] rd_data; // registered read data
    modport owner (output wr_en, wr_addr, wr_data, rd_addr,
                   input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_addr,
                   output rd_data);
endinterface

// File: slot_power_seq.sv
// two-slot power control, mode select, power-on reset, serial port
module slot_power_seq
    import power_seq_pkg::*;
#(
    parameter int         POR_CYCLES = POR_QUAL_CYCLES,
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
)
(
    // clocks and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        link_clk_i,
    // standby supply monitor
    input  wire logic        standby_supply_ok_i,
    // pin port
    input  wire logic [1:0]  slot_main_power_enable_i,
    input  wire logic [1:0]  slot_aux_power_enable_i,
    output logic      [1:0]  fault_n_o,
    // breaker trips from analog side
    input  wire logic [1:0]  main_trip_i,
    input  wire logic [1:0]  aux_trip_i,
    // conversion results
    input  wire logic        adc_valid_i,
    input  wire logic [3:0]  adc_chan_i,
    input  wire logic [7:0]  adc_data_i,
    // serial management port
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    output logic             int_n_o,
    // slot output controls and power-on reset done
    output logic      [1:0]  main_en_o,
    output logic      [1:0]  aux_en_o,
    output logic             por_done_o
);
    localparam int PW = $clog2(POR_CYCLES + 1);
    localparam int NS = 11;

    // refuse a qualification time the counter cannot serve
    if (POR_CYCLES < 1)
    begin
        $error("POR_CYCLES must be at least one");
    end

    // ---- mclk domain ----
    logic          wr_tgl;      // link: write event toggle
    logic          rd_tgl;      // link: read request toggle
    logic [7:0]    wr_cmd;      // link: held write command
    logic [7:0]    wr_data;     // link: held write data
    logic [7:0]    rd_cmd;      // link: held read command
    logic [NS-1:0] async_in;    // pins and link toggles
    logic [NS-1:0] s1;          // first sync stage only
    logic [NS-1:0] s2;          // synced
    logic [NS-1:0] s3;          // delayed for edges
    logic [PW-1:0] por_cnt;     // qualification counter
    logic          por_done;    // registers released
    logic [1:0]    ctl_main;    // serial main enables
    logic [1:0]    ctl_aux;     // serial aux enables
    logic          cfg_serial;  // 1: serial power control
    logic [1:0]    main_fault;  // sticky main breaker
    logic [1:0]    aux_fault;   // sticky aux breaker
    logic [1:0]    pin_fault;   // trip seen in pin mode
    logic [7:0]    rd_cmd_m;    // captured read command
    logic [1:0]    rd_pend;     // read pipeline
    logic [7:0]    rd_word;     // answer to link
    logic          rd_ack;      // answer toggle

    result_mem_if rmem ();

    assign async_in = {rd_tgl, wr_tgl, standby_supply_ok_i,
                       aux_trip_i, main_trip_i,
                       slot_aux_power_enable_i,
                       slot_main_power_enable_i};

    // named views of synced inputs
    wire [1:0] on_pin   = s2[1:0];
    wire [1:0] aux_pin  = s2[3:2];
    wire [1:0] m_trip   = s2[5:4];
    wire [1:0] a_trip   = s2[7:6];
    wire       stby_ok  = s2[8];
    wire       wr_evt   = s2[9] ^ s3[9];
    wire       rd_evt   = s2[10] ^ s3[10];
    wire [1:0] on_fall  = s3[1:0] & ~s2[1:0];
    wire [1:0] aux_fall = s3[3:2] & ~s2[3:2];
    wire       regs_rst = !reset_n_i || !por_done;

    // decoded serial writes
    wire       wr_ctl   = wr_evt && wr_cmd[7:1] == CMD_CTL_A[7:1];
    wire       wr_stat  = wr_evt && wr_cmd[7:1] == CMD_STAT_A[7:1];
    wire       wr_cfg   = wr_evt && wr_cmd == CMD_CFG;
    wire       wslot    = wr_cmd[0];
    // power writes ignored while pins control power
    wire       wr_power = wr_ctl && cfg_serial;

    // requested enables from the selected path
    wire [1:0] req_main = cfg_serial ? ctl_main : on_pin;
    wire [1:0] req_aux  = cfg_serial ? ctl_aux : aux_pin;
    // faulted outputs stay off; nothing before reset ends
    wire [1:0] next_main = por_done ? req_main & ~main_fault : 2'h0;
    wire [1:0] next_aux  = por_done ? req_aux & ~aux_fault : 2'h0;
    // trips only count on enabled outputs
    wire [1:0] main_set  = m_trip & main_en_o;
    wire [1:0] aux_set   = a_trip & aux_en_o;

    // clear when the matching enable is cycled off or by a status write
    logic [1:0] main_clr;
    logic [1:0] aux_clr;
    logic [1:0] stat_clr;
    always_comb
    begin
        main_clr = cfg_serial ? 2'h0 : on_fall;
        aux_clr  = cfg_serial ? 2'h0 : aux_fall;
        stat_clr = 2'h0;
        if (wr_power && !wr_data[CTL_MAIN_BIT])
        begin
            main_clr[wslot] = 1'b1;
        end
        if (wr_power && !wr_data[CTL_AUX_BIT])
        begin
            aux_clr[wslot] = 1'b1;
        end
        if (wr_stat && wr_data[STAT_MAIN_BIT])
        begin
            main_clr[wslot] = 1'b1;
        end
        if (wr_stat && wr_data[STAT_AUX_BIT])
        begin
            aux_clr[wslot] = 1'b1;
        end
        if (wr_stat && wr_data[STAT_PIN_BIT])
        begin
            stat_clr[wslot] = 1'b1;
        end
    end

    // read multiplexer over every register
    wire [0:0] rs = rd_cmd_m[0];
    wire [7:0] ctl_word  = {6'h00, ctl_aux[rs[0]], ctl_main[rs[0]]};
    wire [7:0] stat_word = {5'h00, pin_fault[rs[0]],
                            aux_fault[rs[0]], main_fault[rs[0]]};
    wire [7:0] rd_next =
        (rd_cmd_m[7:4] == CMD_RESULT_BASE[7:4]) ? rmem.rd_data :
        (rd_cmd_m[7:1] == CMD_CTL_A[7:1])       ? ctl_word :
        (rd_cmd_m[7:1] == CMD_STAT_A[7:1])      ? stat_word :
        (rd_cmd_m == CMD_CFG) ? {7'h00, cfg_serial} : 8'h00;

    assign rmem.wr_en   = adc_valid_i;
    assign rmem.wr_addr = adc_chan_i;
    assign rmem.wr_data = adc_data_i;
    assign rmem.rd_addr = rd_cmd_m[RESULT_AW-1:0];

    result_mem u_result_mem (
        .mclk_i (mclk_i),
        .mem    (rmem.store)
    );

    // two-stage synchronisers plus edge stage
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // standby qualification; any dropout restarts it
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || !stby_ok)
        begin
            por_cnt  <= '0;
            por_done <= 1'b0;
        end
        else if (!por_done)
        begin
            if (por_cnt == PW'(POR_CYCLES - 1))
            begin
                por_done <= 1'b1;
            end
            else
            begin
                por_cnt <= por_cnt + 1'b1;
            end
        end
    end

    // control and config registers cleared by reset
    always_ff @(posedge mclk_i)
    begin
        if (regs_rst)
        begin
            ctl_main   <= CTL_RESET;
            ctl_aux    <= CTL_RESET;
            cfg_serial <= CFG_RESET;
        end
        else
        begin
            if (wr_power)  // power writes only in serial mode
            begin
                ctl_main[wslot] <= wr_data[CTL_MAIN_BIT];
                ctl_aux[wslot]  <= wr_data[CTL_AUX_BIT];
            end
            if (wr_cfg)
            begin
                cfg_serial <= wr_data[CFG_SERIAL_BIT];
            end
        end
    end

    // sticky faults, set wins over clear
    always_ff @(posedge mclk_i)
    begin
        if (regs_rst)
        begin
            main_fault <= 2'h0;
            aux_fault  <= 2'h0;
            pin_fault  <= 2'h0;
        end
        else
        begin
            main_fault <= main_set | (main_fault & ~main_clr);
            aux_fault  <= aux_set | (aux_fault & ~aux_clr);
            // flag only trips of pin-enabled outputs
            pin_fault  <= ((main_set | aux_set) & {2{!cfg_serial}})
                        | (pin_fault & ~(stat_clr | main_clr | aux_clr));
        end
    end

    // registered slot outputs and indicators
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            main_en_o  <= 2'h0;
            aux_en_o   <= 2'h0;
            fault_n_o  <= 2'h3;
            int_n_o    <= 1'b1;
            por_done_o <= 1'b0;
        end
        else
        begin
            main_en_o  <= next_main;
            aux_en_o   <= next_aux;
            fault_n_o  <= ~pin_fault;
            int_n_o    <= ~|(main_fault | aux_fault);
            por_done_o <= por_done;
        end
    end

    // read handshake: capture command, wait two cycles, answer
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            rd_cmd_m <= 8'h00;
            rd_pend  <= 2'h0;
            rd_word  <= 8'h00;
            rd_ack   <= 1'b0;
        end
        else
        begin
            rd_pend <= {rd_pend[0], rd_evt};
            if (rd_evt)
            begin
                rd_cmd_m <= rd_cmd;
            end
            if (rd_pend[1])
            begin
                rd_word <= rd_next;
                rd_ack  <= ~rd_ack;
            end
        end
    end

    // link domain: oversampling serial slave
    logic       l_run1;   // first sync stage only
    logic       l_run2;   // release from mclk side
    logic [2:0] lp1;      // first sync stage only
    logic [2:0] lp2;      // synced scl, sda, ack
    logic [2:0] lp3;      // delayed for edges
    smb_state_t state;    // byte phase
    logic       in_ack;   // ninth bit in progress
    logic       rw;       // read transfer
    logic       more;     // master acked read byte
    logic [3:0] bits;     // bit counter
    logic [7:0] shreg;    // receive shift
    logic [7:0] tx;       // transmit shift
    logic       oe_n;     // sda driver, low drives 0

    wire scl_s    = lp2[0];
    wire sda_s    = lp2[1];
    wire scl_rise = lp2[0] & ~lp3[0];
    wire scl_fall = ~lp2[0] & lp3[0];
    wire start    = scl_s & lp3[0] & lp3[1] & ~sda_s;
    wire stop     = scl_s & lp3[0] & ~lp3[1] & sda_s;
    wire ack_evt  = lp2[2] ^ lp3[2];
    wire l_rst    = !l_run2;
    wire addr_hit = shreg[7:1] == SLAVE_ADDR;

    // link synchronisers
    always_ff @(posedge link_clk_i)
    begin
        l_run1 <= por_done;
        l_run2 <= l_run1;
        lp1    <= {rd_ack, sda_i, scl_i};
        lp2    <= lp1;
        lp3    <= lp2;
    end

    // byte engine
    always_ff @(posedge link_clk_i)
    begin
        if (l_rst || stop)
        begin
            state  <= SMB_IDLE;
            in_ack <= 1'b0;
            oe_n   <= 1'b1;
            bits   <= 4'h0;
            if (l_rst)
            begin
                rw      <= 1'b0;
                more    <= 1'b0;
                shreg   <= 8'h00;
                tx      <= 8'h00;
                wr_tgl  <= 1'b0;
                rd_tgl  <= 1'b0;
                wr_cmd  <= 8'h00;
                wr_data <= 8'h00;
                rd_cmd  <= 8'h00;
            end
        end
        else if (start)
        begin
            state  <= SMB_ADDR;
            in_ack <= 1'b0;
            oe_n   <= 1'b1;
            bits   <= 4'h0;
        end
        else
        begin
            if (ack_evt)
            begin
                tx <= rd_word;
            end
            if (scl_rise && state != SMB_IDLE)
            begin
                if (in_ack)
                begin
                    more <= !sda_s;
                end
                else if (state != SMB_RDATA)
                begin
                    shreg <= {shreg[6:0], sda_s};
                    bits  <= bits + 1'b1;
                end
            end
            if (scl_fall && state != SMB_IDLE)
            begin
                if (in_ack)
                begin
                    in_ack <= 1'b0;
                    oe_n   <= 1'b1;
                    unique case (state)
                        SMB_ADDR:
                        begin
                            state <= rw ? SMB_RDATA : SMB_CMD;
                            if (rw)
                            begin
                                oe_n <= tx[7];
                                tx   <= {tx[6:0], 1'b1};
                                bits <= 4'h1;
                            end
                        end
                        SMB_CMD:   state <= SMB_WDATA;
                        SMB_WDATA: state <= SMB_WDATA;
                        SMB_RDATA:
                        begin
                            state <= more ? SMB_RDATA : SMB_IDLE;
                            oe_n  <= more ? tx[7] : 1'b1;
                            tx    <= {tx[6:0], 1'b1};
                            bits  <= 4'h1;
                        end
                        default:   state <= SMB_IDLE;
                    endcase
                end
                else if (state == SMB_RDATA)
                begin
                    if (bits == 4'h8)
                    begin
                        in_ack <= 1'b1;
                        oe_n   <= 1'b1;
                        bits   <= 4'h0;
                    end
                    else
                    begin
                        oe_n <= tx[7];
                        tx   <= {tx[6:0], 1'b1};
                        bits <= bits + 1'b1;
                    end
                end
                else if (bits == 4'h8)
                begin
                    bits   <= 4'h0;
                    in_ack <= 1'b1;
                    oe_n   <= 1'b0;
                    unique case (state)
                        SMB_ADDR:
                        begin
                            rw <= shreg[0];
                            if (!addr_hit)
                            begin
                                state  <= SMB_IDLE;
                                in_ack <= 1'b0;
                                oe_n   <= 1'b1;
                            end
                        end
                        SMB_CMD:
                        begin
                            wr_cmd <= shreg;
                            rd_cmd <= shreg;
                            rd_tgl <= ~rd_tgl;
                        end
                        SMB_WDATA:
                        begin
                            wr_data <= shreg;
                            wr_tgl  <= ~wr_tgl;
                        end
                        default: oe_n <= 1'b1;
                    endcase
                end
            end
        end
    end

    // pin drivers from flops: data is always zero
    always_ff @(posedge link_clk_i)
    begin
        sda_o      <= 1'b0;
        sda_oe_n_o <= oe_n | l_rst;
    end
endmodule

// File: slot_power_seq_sva.sv
// port-level assertion checker for the slot power sequencer
module slot_power_seq_sva
    import power_seq_pkg::*;
#(
    parameter int POR_CYCLES = POR_QUAL_CYCLES
)
(
    // clock, reset, supply and main trips
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic       standby_supply_ok_i,
    input wire logic [1:0] main_trip_i,
    // watched outputs
    input wire logic [1:0] fault_n_o,
    input wire logic       sda_o,
    input wire logic       sda_oe_n_o,
    input wire logic       int_n_o,
    input wire logic [1:0] main_en_o,
    input wire logic [1:0] aux_en_o,
    input wire logic       por_done_o
);
    int ok_cnt; // consecutive standby-valid cycles, saturating

    // count how long standby has stayed valid
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || !standby_supply_ok_i)
            ok_cnt <= 0;
        else if (ok_cnt < POR_CYCLES + 8)
            ok_cnt <= ok_cnt + 1;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    por_outputs_off_a: assert property (
        !por_done_o |-> main_en_o == 2'h0 && aux_en_o == 2'h0)
        else $error("slot output on before power-on reset done");
    por_quiet_a: assert property (
        !por_done_o [*2] |-> fault_n_o == 2'h3 && int_n_o)
        else $error("fault or interrupt shown during qualification");
    sda_low_only_a: assert property (!sda_o)
        else $error("data line driven high");
    sda_released_a: assert property (
        !por_done_o [*8] ##4 !por_done_o |-> sda_oe_n_o)
        else $error("data line held while in reset");
    standby_drop_a: assert property (
        $fell(standby_supply_ok_i) |-> ##[1:5] !por_done_o)
        else $error("standby dropout did not restart reset");
    por_qual_a: assert property (
        $rose(por_done_o) |-> ok_cnt >= POR_CYCLES)
        else $error("reset finished before qualification time");
    trip_cut_a: assert property (
        main_en_o[0] && main_trip_i[0] |-> ##[1:6] !main_en_o[0])
        else $error("main output stayed on after trip");
    fault_int_a: assert property (
        $fell(fault_n_o[0]) |-> ##[0:2] !int_n_o)
        else $error("fault pin without interrupt");
endmodule

bind slot_power_seq slot_power_seq_sva #(.POR_CYCLES(POR_CYCLES)) chk (
    .mclk_i, .reset_n_i, .standby_supply_ok_i, .main_trip_i, .fault_n_o,
    .sda_o, .sda_oe_n_o, .int_n_o, .main_en_o, .aux_en_o, .por_done_o);

// File: slot_power_seq_test.sv
// self-checking bench for the slot power sequencer
module slot_power_seq_test
    import power_seq_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POR_N = 50; // shortened qualification
    logic       mclk_i, link_clk_i, reset_n_i, stby, scl, host_low;
    logic [1:0] pin_main, pin_aux, mtrip, atrip;
    logic       adc_v;
    logic [3:0] adc_ch;
    logic [7:0] adc_d;
    wire logic  sda_d, sda_oe_n, int_n, por_done, sda_line;
    wire logic [1:0] fault_n, main_en, aux_en;
    int         error_cnt = 0;
    int         tests_run = 0;

    // open-drain data line with pull-up
    assign sda_line = !(host_low || (!sda_oe_n && !sda_d));

    slot_power_seq #(.POR_CYCLES(POR_N)) dut (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
        .standby_supply_ok_i(stby), .slot_main_power_enable_i(pin_main),
        .slot_aux_power_enable_i(pin_aux), .fault_n_o(fault_n),
        .main_trip_i(mtrip), .aux_trip_i(atrip), .adc_valid_i(adc_v),
        .adc_chan_i(adc_ch), .adc_data_i(adc_d), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n),
        .int_n_o(int_n), .main_en_o(main_en), .aux_en_o(aux_en),
        .por_done_o(por_done));
    smbus_host_model #(.HALF_CYC(20)) host (.link_clk_i(link_clk_i),
        .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low));

    // main clock, 4 ns
    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // link clock, 12 ns, offset phase
    initial
    begin
        link_clk_i = 1'b0;
        #3.7;
        forever #6 link_clk_i = ~link_clk_i;
    end
    // compare and report
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // verdict and end of run
    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // wait whole main cycles
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // register write over the serial port
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        logic [7:0] q;
        logic       r;
        host.start();
        host.xbyte({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, q, r);
        check("addr ack", 8'h00, {7'h0, r});
        host.xbyte(cmd, 1'b1, q, r);
        host.xbyte(d, 1'b1, q, r);
        check("data ack", 8'h00, {7'h0, r});
        host.stop();
        cyc(1);
    endtask
    // register read with repeated start, ends with no-acknowledge
    task automatic rd(input logic [7:0] cmd, output logic [7:0] q);
        logic [7:0] x;
        logic       r;
        host.start();
        host.xbyte({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, x, r);
        host.xbyte(cmd, 1'b1, x, r);
        host.start();
        host.xbyte({SLAVE_ADDR_DEFAULT, 1'b1}, 1'b1, x, r);
        host.xbyte(8'hff, 1'b1, q, r);
        host.stop();
        cyc(1);
    endtask
    // qualification: early pin requests stay off until done
    task automatic t_por();
        int n;
        pin_main <= 2'h3;
        cyc(20);
        check("por idle", 8'h00, {7'h0, por_done});
        stby <= 1'b1;
        n = 0;
        while (por_done !== 1'b1 && n < POR_N + 20)
        begin
            check("held off", 8'h00, {6'h0, main_en});
            cyc(1);
            n++;
        end
        check("por time", 8'h01, {7'h0, n > POR_N && n <= POR_N + 6});
        cyc(3);
        check("main on", 8'h03, {6'h0, main_en});
        pin_main <= 2'h0;
        cyc(6);
    endtask
    // pin mode: trips, fault pins, status, selective clearing
    task automatic t_pin();
        logic [7:0] q;
        pin_main <= 2'h1;
        pin_aux <= 2'h2;
        wr(CMD_STAT_B, 8'h00); // no power writes in pin mode
        check("pin on", 8'h09, {4'h0, aux_en, main_en});
        mtrip <= 2'h1;
        atrip <= 2'h2;
        cyc(8);
        mtrip <= 2'h0;
        atrip <= 2'h0;
        check("trip", 8'h00, {2'h0, fault_n, aux_en, main_en});
        check("int", 8'h00, {7'h0, int_n});
        rd(CMD_STAT_A, q);
        check("stat a", 8'h05, q);
        rd(CMD_STAT_B, q);
        check("stat b", 8'h06, q);
        pin_main <= 2'h0;
        cyc(8);
        check("main clr", 8'h01, {6'h0, fault_n});
        pin_aux <= 2'h0;
        cyc(8);
        pin_main <= 2'h1;
        pin_aux <= 2'h2;
        cyc(8);
        check("re-on", 8'h79, {1'b0, fault_n, int_n, aux_en, main_en});
        pin_main <= 2'h0;
        pin_aux <= 2'h0;
        cyc(8);
    endtask
    // serial mode with pins held low: control, trip, results
    task automatic t_serial();
        logic [7:0] q;
        logic       r;
        adc_ch <= 4'h5;
        adc_d <= 8'ha5;
        adc_v <= 1'b1;
        cyc(1);
        adc_v <= 1'b0;
        host.start();
        host.xbyte({7'h2d, 1'b0}, 1'b1, q, r);
        host.stop();
        check("bad addr", 8'h01, {7'h0, r});
        wr(CMD_CFG, 8'h01); // pins stay low from here
        wr(CMD_CTL_A, 8'h03);
        check("ser on", 8'h05, {4'h0, aux_en, main_en});
        mtrip <= 2'h1;
        cyc(8);
        mtrip <= 2'h0;
        check("ser trip", 8'h34, {1'b0, int_n, fault_n, aux_en, main_en});
        wr(CMD_CTL_A, 8'h02);
        wr(CMD_CTL_A, 8'h03);
        check("ser clr", 8'h05, {4'h0, aux_en, main_en});
        rd(CMD_RESULT_BASE + 8'h05, q);
        check("result", 8'ha5, q);
    endtask
    // standby dropout: full requalification, result kept
    task automatic t_cycle();
        logic [7:0] q;
        stby <= 1'b0;
        cyc(8);
        check("drop", 8'h00, {3'h0, por_done, aux_en, main_en});
        stby <= 1'b1;
        cyc(POR_N - 4);
        check("requal", 8'h00, {7'h0, por_done});
        cyc(12);
        check("back", 8'h10, {3'h0, por_done, aux_en, main_en});
        rd(CMD_CFG, q);
        check("cfg clr", 8'h00, q);
        rd(CMD_RESULT_BASE + 8'h05, q);
        check("kept", 8'ha5, q);
    endtask
    // main sequence
    initial
    begin
        reset_n_i = 1'b0;
        stby = 1'b0;
        pin_main = 2'h0;
        pin_aux = 2'h0;
        mtrip = 2'h0;
        atrip = 2'h0;
        adc_v = 1'b0;
        adc_ch = 4'h0;
        adc_d = 8'h00;
        cyc(5);
        reset_n_i <= 1'b1;
        t_por();
        t_pin();
        t_serial();
        t_cycle();
        finish_test();
    end
    // watchdog against a hang
    initial
    begin
        #300us;
        error_cnt++;
        finish_test();
    end
endmodule

// File: smbus_host_model.sv
// host serial controller model: clock line and open-drain data
module smbus_host_model
#(
    parameter int HALF_CYC = 105 // link cycles per clock half
)
(
    // timing reference
    input  wire logic link_clk_i,
    // bus lines, data resolved with pull-up outside
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle: clock high, data released
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // one clock half
    task automatic half();
        repeat (HALF_CYC) @(posedge link_clk_i);
    endtask
    // start or repeated start: data falls with clock high
    task automatic start();
        sda_low_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_low_o <= 1'b1;
        half();
        scl_o <= 1'b0;
    endtask
    // stop: data rises with clock high
    task automatic stop();
        sda_low_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_low_o <= 1'b0;
        half();
    endtask
    // one bit: set while low, sample on the last link cycle of the high phase
    task automatic xbit(input logic b, output logic r);
        sda_low_o <= !b;
        half();
        scl_o <= 1'b1;
        repeat (HALF_CYC - 1) @(posedge link_clk_i);
        r = sda_i;
        @(posedge link_clk_i);
        scl_o <= 1'b0;
    endtask
    // eight bits msb first, then the acknowledge bit
    task automatic xbyte(input logic [7:0] d, input logic a9,
                         output logic [7:0] q, output logic r9);
        for (int i = 7; i >= 0; i--)
            xbit(d[i], q[i]);
        xbit(a9, r9);
    endtask
endmodule
